/* File: design/msc_irq_detect.sv */
// msc_irq_detect: turns the interrupt pin into a request according to
// the chosen edge and level sensitivity.
// assumes the pin is synchronous to the core clock.
`timescale 1ns/1ps
module msc_irq_detect (
  input  wire logic  i_core_clk,
  input  wire logic  i_resetn,
  msc_sense_if.det   sense
);
  logic pin_d_ff;  // pin one cycle ago
  logic req_ff;    // registered request
  logic nxt_req;   // request for the next cycle
  logic fell;      // high to low this cycle
  logic rose;      // low to high this cycle

  assign fell = pin_d_ff & ~sense.pin;
  assign rose = ~pin_d_ff & sense.pin;

  always_comb begin
    unique case ({sense.rise_sel, sense.fall_sel})
      2'b00: nxt_req = fell | ~sense.pin;  // low level holds request
      2'b01: nxt_req = fell;
      2'b10: nxt_req = rose;
      2'b11: nxt_req = fell | rose;
    endcase
  end

  // pin history; reset idles high so a low pin after reset counts as a falling edge
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_d_ff <= 1'b1;
    end else begin
      pin_d_ff <= sense.pin;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      req_ff <= 1'b0;
    end else begin
      req_ff <= sense.enable & nxt_req;
    end
  end

  assign sense.req = req_ff;

  a_rise_ignored: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    (!sense.rise_sel && sense.fall_sel && rose) |=> !req_ff)
    else $error("rising edge raised request in falling-only mode");
endmodule // msc_irq_detect

/* File: design/msc_pkg.sv */
// msc_pkg: offsets, field positions, reset values and counts shared by
// the miscellaneous system control block and its testbench.
// assumes a 32-bit avalon-mm register bus with byte addresses.
package msc_pkg;
  // byte offsets of the registers on the bus
  localparam logic [7:0] MISC_OFS   = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] MASK_OFS   = 8'h14;
  // field positions of the control register
  localparam int POR_BIT     = 7;
  localparam int RISE_BIT    = 6;
  localparam int FALL_BIT    = 5;
  localparam int EXT_EN_BIT  = 4;
  localparam int SPEED_A_BIT = 3;
  localparam int SPEED_B_BIT = 2;
  localparam int SLOW_BIT    = 1;
  localparam int WATCHDOG_KICK_ENABLE_BIT    = 0;
  // event positions in status and mask
  localparam int EV_KICK    = 0;
  localparam int EV_REFUSED = 1;
  localparam int EV_STOP    = 2;
  localparam int EV_EXT_IRQ = 3;
  localparam int EV_W       = 4;
  // values after reset
  localparam logic          RISE_RST   = 1'b0;
  localparam logic          FALL_RST   = 1'b0;
  localparam logic          EXT_EN_RST = 1'b1;
  localparam logic          SPEED_RST  = 1'b0;
  localparam logic          SLOW_RST   = 1'b0;
  localparam logic [3:0]    EV_RST     = 4'h0;
  // modulator repetition periods in timer clocks
  localparam logic [12:0] MOD_PERIOD_SLOW = 13'h1000;
  localparam logic [12:0] MOD_PERIOD_FAST = 13'h0100;
  // oscillator divide ratios for the bus rate
  localparam logic [5:0]  BUS_DIV_SLOW = 6'h20;
  localparam logic [5:0]  BUS_DIV_FAST = 6'h02;
endpackage

/* File: design/msc_sense_if.sv */
// msc_sense_if: sensitivity choice and request between the control
// register and the external interrupt detector.
// assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface msc_sense_if;
  logic rise_sel;  // rising edge chosen
  logic fall_sel;  // falling edge chosen
  logic enable;    // external interrupt function on
  logic pin;       // interrupt pin level
  logic req;       // registered request pulse or level
  modport ctrl (output rise_sel, fall_sel, enable, pin, input req);
  modport det  (input rise_sel, fall_sel, enable, pin, output req);
endinterface

/* File: design/msc_top.sv */
// msc_top: eight-bit miscellaneous system control and status register
// with interrupt sensitivity, modulator speeds, bus slow mode, watchdog
// enable and kick, and charge pump handling in wait and stop.
// assumes an avalon-mm master on the core clock and a reset controller
// that flags power-on resets on i_power_on.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
module msc_top (
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  input  wire logic [7:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  output logic             o_irq,
  input  wire logic        i_power_on,
  input  wire logic        i_watchdog_kick_enable_option,
  input  wire logic        i_cpu_imask,
  input  wire logic        i_irq_pin,
  input  wire logic        i_stop_mode,
  input  wire logic        i_wait_mode,
  input  wire logic        i_pump_request,
  input  wire logic        i_converter_rc_select,
  output logic             o_ext_irq_req,
  output logic      [12:0] o_modulator_a_period,
  output logic      [12:0] o_modulator_b_period,
  output logic             o_bus_clk_en,
  output logic             o_watchdog_kick_enable_enable,
  output logic             o_watchdog_kick_enable_kick,
  output logic             o_pump_enable,
  output logic             o_pump_clk_rc,
  output logic             o_eeprom_read_force
);
  // bus handshake
  logic        ack_ff;       // answer cycle of an access
  logic [31:0] rdata_ff;     // read data held for the master
  logic        wr_go;        // write takes effect this edge
  logic        misc_wr;      // accepted write to the control register
  logic        st_wr;        // accepted write to status
  logic        mk_wr;        // accepted write to mask
  logic [7:0]  wbyte;        // low byte of write data
  // control register fields
  logic        por_ff;       // power-on flag
  logic        rise_ff;      // irq_rising_select
  logic        fall_ff;      // irq_falling_select
  logic        ext_en_ff;    // ext_irq_enable
  logic        speed_a_ff;   // modulator_a_speed
  logic        speed_b_ff;   // modulator_b_speed
  logic        slow_ff;      // bus_slow_select
  logic        watchdog_kick_enable_ff;      // watchdog_kick_enable
  logic [7:0]  misc_val;     // assembled register image
  // housekeeping
  logic        loaded_ff;    // first edge after reset has passed
  logic        stop_d_ff;    // stop level one cycle ago
  logic        stop_entry;   // stop mode just began
  logic        kick_ff;      // watchdog kick pulse
  logic [4:0]  div_cnt_ff;   // bus rate divider
  logic        clk_en_ff;    // bus enable pulse
  logic [3:0]  st_ff;        // sticky event status
  logic [3:0]  mk_ff;        // event mask
  logic [3:0]  events;       // events of this cycle
  logic [5:0]  div_ratio;    // current divide ratio

  msc_sense_if sense_if ();

  // one answer cycle: waitrequest drops on the first edge of a request
  assign o_waitrequest = (i_read | i_write) & ~ack_ff;
  assign wr_go   = i_write & ack_ff;
  assign wbyte   = i_writedata[7:0];
  assign misc_wr = wr_go & (i_address == msc_pkg::MISC_OFS);
  assign st_wr   = wr_go & (i_address == msc_pkg::STATUS_OFS);
  assign mk_wr   = wr_go & (i_address == msc_pkg::MASK_OFS);

  // answer strobe toggles so back-to-back requests each wait one cycle
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (i_read | i_write) & ~ack_ff;
    end
  end

  // register image, all eight bits readable
  assign misc_val = {por_ff, rise_ff, fall_ff, ext_en_ff,
                     speed_a_ff, speed_b_ff, slow_ff, watchdog_kick_enable_ff};

  // read data captured on the waiting edge; unmapped reads as zero
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_ff <= 32'h0;
    end else if (i_read & ~ack_ff) begin
      unique case (i_address)
        msc_pkg::MISC_OFS:   rdata_ff <= {24'h0, misc_val};
        msc_pkg::STATUS_OFS: rdata_ff <= {28'h0, st_ff};
        msc_pkg::MASK_OFS:   rdata_ff <= {28'h0, mk_ff};
        default:             rdata_ff <= 32'h0;
      endcase
    end
  end
  assign o_readdata = rdata_ff;

  // marks the first edge after release for strap loading
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      loaded_ff <= 1'b0;
    end else begin
      loaded_ff <= 1'b1;
    end
  end

  // flag survives external reset
  // no async reset on purpose: only a power-on may set it
  always_ff @(posedge i_core_clk) begin
    if (i_power_on) begin
      por_ff <= 1'b1;  // set wins over a clearing write
    end else if (misc_wr && !wbyte[msc_pkg::POR_BIT]) begin
      por_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rise_ff <= msc_pkg::RISE_RST;
      fall_ff <= msc_pkg::FALL_RST;
    end else if (misc_wr && i_cpu_imask) begin
      rise_ff <= wbyte[msc_pkg::RISE_BIT];
      fall_ff <= wbyte[msc_pkg::FALL_BIT];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ext_en_ff <= msc_pkg::EXT_EN_RST;
    end else if (misc_wr && i_cpu_imask) begin
      ext_en_ff <= wbyte[msc_pkg::EXT_EN_BIT];
    end
  end

  // modulator speeds are not double buffered; software orders its writes
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      speed_a_ff <= msc_pkg::SPEED_RST;
      speed_b_ff <= msc_pkg::SPEED_RST;
    end else if (misc_wr) begin
      speed_a_ff <= wbyte[msc_pkg::SPEED_A_BIT];
      speed_b_ff <= wbyte[msc_pkg::SPEED_B_BIT];
    end
  end

  assign o_modulator_a_period = speed_a_ff ? msc_pkg::MOD_PERIOD_SLOW
                                           : msc_pkg::MOD_PERIOD_FAST;
  assign o_modulator_b_period = speed_b_ff ? msc_pkg::MOD_PERIOD_SLOW
                                           : msc_pkg::MOD_PERIOD_FAST;

  // stop entry is the rising edge of the stop level
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stop_d_ff <= 1'b0;
    end else begin
      stop_d_ff <= i_stop_mode;
    end
  end
  assign stop_entry = i_stop_mode & ~stop_d_ff;

  // stop entry beats a setting write
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      slow_ff <= msc_pkg::SLOW_RST;
    end else if (stop_entry) begin
      slow_ff <= 1'b0;
    end else if (misc_wr) begin
      slow_ff <= wbyte[msc_pkg::SLOW_BIT];
    end
  end

  // bus rate divider on the oscillator clock
  assign div_ratio = slow_ff ? msc_pkg::BUS_DIV_SLOW
                             : msc_pkg::BUS_DIV_FAST;
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_cnt_ff <= 5'h0;
      clk_en_ff  <= 1'b0;
    end else if ({1'b0, div_cnt_ff} >= div_ratio - 6'h1) begin
      // >= so a switch to fast mode mid-count ends at once
      div_cnt_ff <= 5'h0;
      clk_en_ff  <= 1'b1;
    end else begin
      div_cnt_ff <= div_cnt_ff + 5'h1;
      clk_en_ff  <= 1'b0;
    end
  end
  assign o_bus_clk_en = clk_en_ff;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      watchdog_kick_enable_ff <= 1'b0;
    end else if (!loaded_ff) begin
      watchdog_kick_enable_ff <= i_watchdog_kick_enable_option;
    end else if (misc_wr && wbyte[msc_pkg::WATCHDOG_KICK_ENABLE_BIT]) begin
      watchdog_kick_enable_ff <= 1'b1;
    end
  end
  assign o_watchdog_kick_enable_enable = watchdog_kick_enable_ff;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      kick_ff <= 1'b0;
    end else begin
      kick_ff <= misc_wr & wbyte[msc_pkg::WATCHDOG_KICK_ENABLE_BIT];
    end
  end
  assign o_watchdog_kick_enable_kick = kick_ff;

  // wait does not gate the pump
  assign o_pump_enable = i_pump_request & ~i_stop_mode;
  assign o_eeprom_read_force = i_stop_mode;
  assign o_pump_clk_rc = i_converter_rc_select;

  // external interrupt detector
  assign sense_if.rise_sel = rise_ff;
  assign sense_if.fall_sel = fall_ff;
  assign sense_if.enable   = ext_en_ff;
  assign sense_if.pin      = i_irq_pin;
  msc_irq_detect u_detect (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .sense      (sense_if.det)
  );
  assign o_ext_irq_req = sense_if.req;

  // events of this cycle; a refused write is any control register write while i_cpu_imask is low
  always_comb begin
    events = 4'h0;
    events[msc_pkg::EV_KICK]    = kick_ff;
    events[msc_pkg::EV_REFUSED] = misc_wr & ~i_cpu_imask;
    events[msc_pkg::EV_STOP]    = stop_entry;
    events[msc_pkg::EV_EXT_IRQ] = sense_if.req;
  end

  // sticky status: a new event wins over a write-one clear
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_ff <= msc_pkg::EV_RST;
    end else begin
      st_ff <= (st_ff & ~(st_wr ? i_writedata[3:0] : 4'h0)) | events;
    end
  end

  // interrupt mask, one enables the event
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mk_ff <= msc_pkg::EV_RST;
    end else if (mk_wr) begin
      mk_ff <= i_writedata[3:0];
    end
  end
  assign o_irq = |(st_ff & mk_ff);

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  // watched through reset too: the flag has no reset and is set during it
  a_por_setting: assert property (disable iff (1'b0)
    i_power_on |=> por_ff)
    else $error("power-on did not set the flag");
  a_sense_refused: assert property (
    (misc_wr && !i_cpu_imask) |=> $stable({rise_ff, fall_ff}))
    else $error("sensitivity changed on refused write");
  a_enable_taken: assert property (
    (misc_wr && i_cpu_imask) |=> ext_en_ff == $past(wbyte[4]))
    else $error("enable write not taken");
  a_period_a_sel: assert property (
    misc_wr |=> o_modulator_a_period ==
      ($past(wbyte[3]) ? 13'h1000 : 13'h0100))
    else $error("modulator a period wrong");
  a_period_b_sel: assert property (
    misc_wr |=> o_modulator_b_period ==
      ($past(wbyte[2]) ? 13'h1000 : 13'h0100))
    else $error("modulator b period wrong");
  a_slow_divide: assert property (
    (clk_en_ff && slow_ff) ##1 slow_ff [*8] |-> !clk_en_ff)
    else $error("slow bus pulse came too soon");
  a_stop_clears: assert property (stop_entry |=> !slow_ff)
    else $error("slow mode survived stop entry");
  a_kick_pulse: assert property (
    (misc_wr && wbyte[0]) |=> o_watchdog_kick_enable_kick ##1 o_watchdog_kick_enable_enable)
    else $error("kick write gave no kick");
  a_watchdog_kick_enable_kept: assert property (watchdog_kick_enable_ff |=> watchdog_kick_enable_ff)
    else $error("watchdog disabled by software");
  a_watchdog_kick_enable_strap: assert property (
    !loaded_ff |=> watchdog_kick_enable_ff == $past(i_watchdog_kick_enable_option))
    else $error("watchdog bit not loaded from option");
  a_pump_wait: assert property (
    (i_wait_mode && i_pump_request && !i_stop_mode) |-> o_pump_enable)
    else $error("pump stopped in wait");
  a_pump_stop: assert property (
    i_stop_mode |-> !o_pump_enable && o_eeprom_read_force)
    else $error("pump running in stop");

  c_kick_write:    cover property (misc_wr && wbyte[0]);
  c_refused_write: cover property (misc_wr && !i_cpu_imask);
  c_stop_in_slow:  cover property (slow_ff && stop_entry);
  c_irq_raised:    cover property (!o_irq ##1 o_irq);
endmodule // msc_top

/* File: sim/testbench.sv */
// testbench: self-checking bench for the miscellaneous system control block.
// assumes msc_top with avalon-mm slave port, one core clock at 200 mhz.
`timescale 1ns/1ps
module testbench;
  logic        i_core_clk            = 1'b0;  // core clock
  logic        i_resetn              = 1'b0;  // active-low reset
  logic [7:0]  i_address             = 8'h00; // byte address
  logic        i_read                = 1'b0;  // read strobe
  logic        i_write               = 1'b0;  // write strobe
  logic [31:0] i_writedata           = 32'h0; // write data
  logic        i_power_on            = 1'b1;  // power-on flag source
  logic        i_watchdog_kick_enable_option         = 1'b1;  // mask option level
  logic        i_cpu_imask           = 1'b0;  // cpu interrupt mask
  logic        i_irq_pin             = 1'b1;  // idle high pin
  logic        i_stop_mode           = 1'b0;  // core in stop
  logic        i_wait_mode           = 1'b0;  // core in wait
  logic        i_pump_request        = 1'b0;  // charge pump request
  logic        i_converter_rc_select = 1'b0;  // rc clock choice
  logic [31:0] o_readdata;                    // read data
  logic        o_waitrequest;                 // bus stall
  logic        o_irq;                         // level interrupt
  logic        o_ext_irq_req;                 // external request
  logic [12:0] o_modulator_a_period;          // period a
  logic [12:0] o_modulator_b_period;          // period b
  logic        o_bus_clk_en;                  // bus clock enable
  logic        o_watchdog_kick_enable_enable;                 // watchdog on
  logic        o_watchdog_kick_enable_kick;                   // watchdog kick pulse
  logic        o_pump_enable;                 // pump on
  logic        o_pump_clk_rc;                 // pump on rc clock
  logic        o_eeprom_read_force;           // eeprom read mode
  int          error_cnt = 0;                 // mismatches
  int          checks    = 0;                 // comparisons made
  int          kick_n    = 0;                 // kick pulse cycles seen
  int          req_n     = 0;                 // request high cycles seen
  int          gap_cnt   = 0;                 // cycles since enable
  int          last_gap  = 0;                 // spacing of last two enables
  logic [31:0] rd;                            // last read word
  int          exp_req[4] = '{4, 1, 1, 2};    // request cycles per code

  msc_top dut (
    .i_core_clk            (i_core_clk),
    .i_resetn              (i_resetn),
    .i_address             (i_address),
    .i_read                (i_read),
    .i_write               (i_write),
    .i_writedata           (i_writedata),
    .o_readdata            (o_readdata),
    .o_waitrequest         (o_waitrequest),
    .o_irq                 (o_irq),
    .i_power_on            (i_power_on),
    .i_watchdog_kick_enable_option         (i_watchdog_kick_enable_option),
    .i_cpu_imask           (i_cpu_imask),
    .i_irq_pin             (i_irq_pin),
    .i_stop_mode           (i_stop_mode),
    .i_wait_mode           (i_wait_mode),
    .i_pump_request        (i_pump_request),
    .i_converter_rc_select (i_converter_rc_select),
    .o_ext_irq_req         (o_ext_irq_req),
    .o_modulator_a_period  (o_modulator_a_period),
    .o_modulator_b_period  (o_modulator_b_period),
    .o_bus_clk_en          (o_bus_clk_en),
    .o_watchdog_kick_enable_enable         (o_watchdog_kick_enable_enable),
    .o_watchdog_kick_enable_kick           (o_watchdog_kick_enable_kick),
    .o_pump_enable         (o_pump_enable),
    .o_pump_clk_rc         (o_pump_clk_rc),
    .o_eeprom_read_force   (o_eeprom_read_force)
  );

  // 5 ns period clock
  always #2.5 i_core_clk = ~i_core_clk;

  // monitors sample on the falling edge, where registered outputs are settled
  always @(negedge i_core_clk) begin
    if (o_watchdog_kick_enable_kick === 1'b1) kick_n++;
    if (o_ext_irq_req === 1'b1) req_n++;
    if (o_bus_clk_en === 1'b1) begin
      last_gap = gap_cnt;
      gap_cnt  = 1;
    end else begin
      gap_cnt++;
    end
  end

  // verdict and end of run, shared by the main sequence and timeouts
  task automatic stop_test();
    if (error_cnt == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // compare a bus word or port vector
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // compare a single flag
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // compare an event count
  task automatic chk_cnt(input int got, input int exp);
    checks++;
    if (got != exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  // one avalon access; waitrequest is read where settled before the edge
  task automatic bus(input logic is_rd, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    logic ok;
    int   n;
    ok = 1'b0;
    q  = 32'h0;
    @(posedge i_core_clk);
    i_read      <= is_rd;
    i_write     <= ~is_rd;
    i_address   <= a;
    i_writedata <= d;
    for (n = 0; n < 20 && !ok; n++) begin
      @(negedge i_core_clk);
      ok = (o_waitrequest === 1'b0);
      q  = o_readdata;
      @(posedge i_core_clk);
    end
    i_read  <= 1'b0;
    i_write <= 1'b0;
    if (!ok) begin
      error_cnt++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask

  task automatic rdreg(input logic [7:0] a);
    bus(1'b1, a, 32'h0, rd);
  endtask

  // pin low four cycles, then high again
  task automatic pin_pulse();
    @(posedge i_core_clk) i_irq_pin <= 1'b0;
    cyc(4);
    i_irq_pin <= 1'b1;
    cyc(6);
  endtask

  initial begin
    int k;
    cyc(2);
    i_resetn   <= 1'b1;
    i_power_on <= 1'b0;
    cyc(2);
    rdreg(msc_pkg::MISC_OFS);
    chk_word(rd, 32'h91);
    chk_bit(o_watchdog_kick_enable_enable, 1'b1);
    chk_word(o_modulator_a_period, 13'h0100);
    chk_word(o_modulator_b_period, 13'h0100);
    chk_cnt(last_gap, 2);
    rdreg(msc_pkg::STATUS_OFS);
    chk_word(rd, 32'h0);
    // unmapped place is ignored and reads zero
    wr(8'h20, 32'hff);
    rdreg(8'h20);
    chk_word(rd, 32'h0);
    // refused write: 6..4 hold, bit7 cleared by zero, bit0 zero ignored
    // speed bits set before any modulator value write
    wr(msc_pkg::MISC_OFS, 32'h7e);
    rdreg(msc_pkg::MISC_OFS);
    chk_word(rd, 32'h1f);
    chk_cnt(kick_n, 0);
    chk_word(o_modulator_a_period, 13'h1000);
    chk_word(o_modulator_b_period, 13'h1000);
    cyc(70);
    chk_cnt(last_gap, 32);
    rdreg(msc_pkg::STATUS_OFS);
    chk_word(rd, 32'h2);
    wr(msc_pkg::STATUS_OFS, 32'h2);
    // accepted write; bit7 one cannot set the flag; kick raises irq
    i_cpu_imask <= 1'b1;
    wr(msc_pkg::MASK_OFS, 32'h1);
    wr(msc_pkg::MISC_OFS, 32'he1);
    // status takes the kick one edge after the pulse: look an edge later
    cyc(3);
    chk_cnt(kick_n, 1);
    chk_bit(o_irq, 1'b1);
    rdreg(msc_pkg::MISC_OFS);
    chk_word(rd, 32'h61);
    cyc(6);
    chk_cnt(last_gap, 2);
    wr(msc_pkg::STATUS_OFS, 32'h1);
    cyc(1);
    chk_bit(o_irq, 1'b0);
    // masked kick leaves irq low
    wr(msc_pkg::MASK_OFS, 32'h0);
    wr(msc_pkg::MISC_OFS, 32'h61);
    cyc(3);
    chk_bit(o_irq, 1'b0);
    wr(msc_pkg::STATUS_OFS, 32'hf);
    // every sensitivity code, enable on
    for (k = 0; k < 4; k++) begin
      wr(msc_pkg::MISC_OFS, 32'h10 | (k << 5));
      cyc(3);
      req_n = 0;
      pin_pulse();
      chk_cnt(req_n, exp_req[k]);
    end
    rdreg(msc_pkg::STATUS_OFS);
    chk_word(rd, 32'h8);
    wr(msc_pkg::STATUS_OFS, 32'h8);
    // enable off blocks every request
    wr(msc_pkg::MISC_OFS, 32'h60);
    cyc(3);
    req_n = 0;
    pin_pulse();
    chk_cnt(req_n, 0);
    // wait keeps the pump, stop clears slow and forces read mode
    wr(msc_pkg::MISC_OFS, 32'h12);
    i_pump_request        <= 1'b1;
    i_wait_mode           <= 1'b1;
    i_converter_rc_select <= 1'b1;
    cyc(2);
    chk_bit(o_pump_enable, 1'b1);
    chk_bit(o_pump_clk_rc, 1'b1);
    chk_bit(o_eeprom_read_force, 1'b0);
    i_stop_mode <= 1'b1;
    cyc(3);
    chk_bit(o_pump_enable, 1'b0);
    chk_bit(o_eeprom_read_force, 1'b1);
    rdreg(msc_pkg::MISC_OFS);
    // watchdog bit stays set: a zero written to it has no effect
    chk_word(rd, 32'h11);
    rdreg(msc_pkg::STATUS_OFS);
    chk_word(rd, 32'h4);
    // external reset: flag kept clear, watchdog bit from option
    i_stop_mode    <= 1'b0;
    i_wait_mode    <= 1'b0;
    i_watchdog_kick_enable_option  <= 1'b0;
    i_resetn       <= 1'b0;
    cyc(2);
    i_resetn <= 1'b1;
    cyc(2);
    chk_bit(o_watchdog_kick_enable_enable, 1'b0);
    rdreg(msc_pkg::MISC_OFS);
    chk_word(rd, 32'h10);
    wr(msc_pkg::MISC_OFS, 32'h11);
    cyc(2);
    chk_bit(o_watchdog_kick_enable_enable, 1'b1);
    stop_test();
  end
endmodule // testbench
